/* File: logic/cps_grouping.sv */
// Configurable power stage grouping: register, decode, command steering and diagnosis routing
`timescale 1ns/1ps
module cps_grouping (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_sel_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic diag_rd_in,
    input wire logic [cps_pkg::NUM_STAGES-1:0] per_stage_command_in,
    input wire logic [cps_pkg::NUM_STAGES-1:0] oc_sense_in,
    input wire logic [2*cps_pkg::NUM_STAGES-1:0] off_sense_in,
    output logic [cps_pkg::NUM_STAGES-1:0] stage_drive_out,
    output logic [cps_pkg::NUM_STAGES-1:0] stage_grouped_out,
    output logic [2*cps_pkg::NUM_STAGES-1:0] diag_slot_out,
    output logic [7:0] cps_grouping_config_out,
    output logic [7:0] general_config_seven_out
);
    import cps_pkg::*;

    // ****************************************
    // Reset release and input synchronisers
    // ****************************************
    logic rst_meta;
    logic rst_n;
    logic [NUM_STAGES-1:0] oc_meta;
    logic [NUM_STAGES-1:0] oc_sync;
    logic [2*NUM_STAGES-1:0] off_meta;
    logic [2*NUM_STAGES-1:0] off_sync;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            oc_meta <= '0;
            oc_sync <= '0;
            off_meta <= '0;
            off_sync <= '0;
        end else begin
            oc_meta <= oc_sense_in;
            oc_sync <= oc_meta;
            off_meta <= off_sense_in;
            off_sync <= off_meta;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [7:0] grouping_cfg;
    logic [7:0] general_seven;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            grouping_cfg <= GROUPING_RESET;
            general_seven <= GENERAL_SEVEN_RESET;
        end else if (reg_wr_in) begin
            if (reg_sel_in == REG_SEL_GROUPING) begin
                grouping_cfg <= reg_wdata_in;
            end else begin
                general_seven <= reg_wdata_in;
            end
        end
    end

    // ****************************************
    // Grouping decode
    // ****************************************
    function automatic group_map_t decode_grouping(input logic [7:0] cfg, input logic inhibit);
        group_map_t m;
        logic [4:0] key;
        for (int i = 0; i < NUM_STAGES; i++) begin
            m.cmd_src[i] = 3'(i);
            m.diag_slot[i] = 3'(i);
            m.grouped[i] = 1'b0;
        end
        key = {cfg[7], cfg[3:0]};
        if (!inhibit) begin
            if (cfg == HS_PAIRS_A) begin
                m.cmd_src[STAGE_21] = STAGE_23;
                m.diag_slot[STAGE_21] = STAGE_23;
                m.cmd_src[STAGE_28] = STAGE_27;
                m.diag_slot[STAGE_28] = STAGE_27;
                m.grouped = 8'hC5;
            end else if (cfg == HS_PAIRS_B) begin
                m.cmd_src[STAGE_26] = STAGE_25;
                m.diag_slot[STAGE_26] = STAGE_25;
                m.cmd_src[STAGE_22] = STAGE_24;
                m.diag_slot[STAGE_24] = STAGE_22;
                m.grouped = 8'h3A;
            end else begin
                case (key)
                    KEY_QUAD_LOWSIDE: begin
                        m.cmd_src[STAGE_22] = STAGE_24;
                        m.cmd_src[STAGE_27] = STAGE_24;
                        m.cmd_src[STAGE_28] = STAGE_24;
                        m.diag_slot[STAGE_24] = STAGE_22;
                        m.diag_slot[STAGE_27] = STAGE_22;
                        m.diag_slot[STAGE_28] = STAGE_22;
                        m.grouped = 8'hCA;
                    end
                    KEY_LOWSIDE_PAIR: begin
                        m.cmd_src[STAGE_22] = STAGE_24;
                        m.diag_slot[STAGE_24] = STAGE_22;
                        m.grouped = 8'h0A;
                    end
                    KEY_TWO_PAIRS: begin
                        m.cmd_src[STAGE_22] = STAGE_24;
                        m.diag_slot[STAGE_24] = STAGE_22;
                        m.cmd_src[STAGE_28] = STAGE_27;
                        m.diag_slot[STAGE_28] = STAGE_27;
                        m.grouped = 8'hCA;
                    end
                    KEY_TRIPLE: begin
                        m.cmd_src[STAGE_27] = STAGE_24;
                        m.cmd_src[STAGE_28] = STAGE_24;
                        m.diag_slot[STAGE_27] = STAGE_24;
                        m.diag_slot[STAGE_28] = STAGE_24;
                        m.grouped = 8'hC8;
                    end
                    default: begin
                    end
                endcase
            end
        end
        return m;
    endfunction : decode_grouping

    group_map_t map;
    assign map = decode_grouping(grouping_cfg, general_seven[PAR_INHIBIT_BIT]);

    // ****************************************
    // Command steering
    // ****************************************
    logic [NUM_STAGES-1:0] next_drive;
    logic [1:0] stage_code [NUM_STAGES];
    logic [2*NUM_STAGES-1:0] next_diag;

    genvar g;
    generate
        for (g = 0; g < NUM_STAGES; g++) begin : g_stage
            stage_sense_t sense;
            assign next_drive[g] = per_stage_command_in[map.cmd_src[g]];
            assign sense.oc = oc_sync[g];
            assign sense.off_code = off_sync[2*g +: 2];
            stage_fault_latch u_latch (
                .mclk_in(mclk_in),
                .rst_n_in(rst_n),
                .on_in(stage_drive_out[g]),
                .long_filter_in(map.grouped[g]),
                .sense_in(sense),
                .clear_in(diag_rd_in),
                .code_out(stage_code[g])
            );
        end
    endgenerate

    // ****************************************
    // Diagnosis slot routing
    // ****************************************
    always_comb begin
        next_diag = '0;
        for (int s = 0; s < NUM_STAGES; s++) begin
            for (int i = 0; i < NUM_STAGES; i++) begin
                // Worst code of stages on slot
                if (map.diag_slot[i] == 3'(s) && stage_code[i] > next_diag[2*s +: 2]) begin
                    next_diag[2*s +: 2] = stage_code[i];
                end
            end
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    // Registered stage drives
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            stage_drive_out <= '0;
            stage_grouped_out <= '0;
        end else begin
            stage_drive_out <= next_drive;
            stage_grouped_out <= map.grouped;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            diag_slot_out <= '0;
        end else begin
            diag_slot_out <= next_diag;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            cps_grouping_config_out <= GROUPING_RESET;
            general_config_seven_out <= GENERAL_SEVEN_RESET;
        end else begin
            cps_grouping_config_out <= grouping_cfg;
            general_config_seven_out <= general_seven;
        end
    end

endmodule : cps_grouping

/* File: logic/cps_pkg.sv */
// Constants, types and field layouts for the configurable power stage grouping logic
// Operation
// - Paralleling applies only while general_config_seven bit 4 is zero; it resets to one.
// - Stages not named in the selected grouping run as independent single stages.
// - Overcurrent filter is 8 us for paralleled stages, 4 us for single ones.
// - Only bit 3 set: stages 22,24,27,28 paralleled, command 24, diagnosis 22.
// - Only bit 1 set: 22 and 24 paralleled via 24/22; 27, 28 single.
// - Only bit 2 set: pairs 22/24 and 27/28; commands 24, 27; diagnosis 22, 27.
// - Bits 7,3,2 set, 1,0 clear: 24,27,28 paralleled; 24 commands and diagnoses.
// - Encoding 0x36: pairs 21/23 and 27/28, commands 23 and 27, diagnosis 23 and 27.
// - Second high-side encoding: pairs 25/26 and 22/24, commands 24, 25, diagnosis 22, 25.
// - All-single configuration: each stage uses its own command and diagnosis slot.
// - Each stage keeps its own overcurrent detection; off thresholds stay per stage.
// - Each channel holds a two-bit fault code, cleared by every diagnosis read.
// - Off state latches only the first fault; only an on fault overwrites it.
package cps_pkg;

    // ****************************************
    // Stage indices (stage_21 .. stage_28)
    // ****************************************
    localparam int NUM_STAGES = 8;
    localparam logic [2:0] STAGE_21 = 3'h0;
    localparam logic [2:0] STAGE_22 = 3'h1;
    localparam logic [2:0] STAGE_23 = 3'h2;
    localparam logic [2:0] STAGE_24 = 3'h3;
    localparam logic [2:0] STAGE_25 = 3'h4;
    localparam logic [2:0] STAGE_26 = 3'h5;
    localparam logic [2:0] STAGE_27 = 3'h6;
    localparam logic [2:0] STAGE_28 = 3'h7;

    // ****************************************
    // Register access
    // ****************************************
    localparam logic REG_SEL_GENERAL_SEVEN = 1'b0;
    localparam logic REG_SEL_GROUPING = 1'b1;
    localparam logic [7:0] GENERAL_SEVEN_RESET = 8'h10;
    localparam logic [7:0] GROUPING_RESET = 8'h00;
    localparam int PAR_INHIBIT_BIT = 4;

    // ****************************************
    // Grouping encodings, key is bits {7,3,2,1,0}
    // ****************************************
    localparam logic [4:0] KEY_QUAD_LOWSIDE = 5'h08;
    localparam logic [4:0] KEY_LOWSIDE_PAIR = 5'h02;
    localparam logic [4:0] KEY_TWO_PAIRS = 5'h04;
    localparam logic [4:0] KEY_TRIPLE = 5'h1C;
    localparam logic [7:0] HS_PAIRS_A = 8'h36;
    localparam logic [7:0] HS_PAIRS_B = 8'h3A;

    // ****************************************
    // Fault codes and timing
    // ****************************************
    localparam logic [1:0] FAULT_NONE = 2'h0;
    localparam logic [1:0] FAULT_OVERCURRENT = 2'h3;
    localparam int CLK_PERIOD_NS = 40;
    localparam int OC_FILTER_SINGLE_NS = 4000;
    localparam int OC_FILTER_PARALLEL_NS = 8000;
    localparam logic [7:0] OC_CYCLES_SINGLE = 8'((OC_FILTER_SINGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] OC_CYCLES_PARALLEL = 8'((OC_FILTER_PARALLEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef struct packed {
        logic [NUM_STAGES-1:0][2:0] cmd_src;
        logic [NUM_STAGES-1:0][2:0] diag_slot;
        logic [NUM_STAGES-1:0] grouped;
    } group_map_t;

    typedef struct packed {
        logic oc;
        logic [1:0] off_code;
    } stage_sense_t;

endpackage : cps_pkg

/* File: logic/stage_fault_latch.sv */
// Per-stage overcurrent filter and two-bit fault latch
`timescale 1ns/1ps
module stage_fault_latch (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic on_in,
    input wire logic long_filter_in,
    input wire cps_pkg::stage_sense_t sense_in,
    input wire logic clear_in,
    output logic [1:0] code_out
);
    import cps_pkg::*;

    logic [7:0] oc_count;
    logic [7:0] limit;
    logic oc_valid;
    logic [1:0] base_code;
    logic [1:0] next_code;
    logic [7:0] next_count;

    assign limit = long_filter_in ? OC_CYCLES_PARALLEL : OC_CYCLES_SINGLE;
    assign oc_valid = on_in && sense_in.oc && (oc_count >= limit - 8'h01);
    assign next_count = (on_in && sense_in.oc && !oc_valid) ? oc_count + 8'h01 : 8'h00;
    // Read clears, new event still wins
    assign base_code = clear_in ? FAULT_NONE : code_out;
    // First off fault, on fault overwrites
    assign next_code = oc_valid ? FAULT_OVERCURRENT :
                       (!on_in && base_code == FAULT_NONE) ? sense_in.off_code : base_code;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            oc_count <= 8'h00;
            code_out <= FAULT_NONE;
        end else begin
            oc_count <= next_count;
            code_out <= next_code;
        end
    end

endmodule : stage_fault_latch

/* File: verif/cps_grouping_monitor.sv */
// Concurrent checks on the stage grouping block ports
`timescale 1ns/1ps
module cps_grouping_monitor
    import cps_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic diag_rd_in,
    input wire logic [7:0] per_stage_command_in,
    input wire logic [7:0] oc_sense_in,
    input wire logic [15:0] off_sense_in,
    input wire logic [7:0] stage_drive_out,
    input wire logic [7:0] stage_grouped_out,
    input wire logic [15:0] diag_slot_out,
    input wire logic [7:0] cps_grouping_config_out,
    input wire logic [7:0] general_config_seven_out
);
    // ****
    // Mode decode from the readback copies
    // ****
    logic [2:0] live;
    wire logic [7:0] cfg = cps_grouping_config_out;
    wire logic [4:0] key = {cfg[7], cfg[3:0]};
    wire logic par = !general_config_seven_out[PAR_INHIBIT_BIT];
    wire logic ls = cfg != HS_PAIRS_A && cfg != HS_PAIRS_B;
    wire logic [7:0] cmd = per_stage_command_in;
    wire logic [7:0] drv = stage_drive_out;
    wire logic listed = !ls || key == KEY_QUAD_LOWSIDE || key == KEY_LOWSIDE_PAIR || key == KEY_TWO_PAIRS
        || key == KEY_TRIPLE;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            live <= 3'h0;
        end else if (live != 3'h4) begin
            live <= live + 3'h1;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_steady;
        live == 3'h4 && $stable(cfg) && $stable(par);
    endsequence
    sequence s_mode(logic m);
        s_steady ##0 par && m;
    endsequence
    sequence s_quiet;
        (off_sense_in == 16'h0000 && oc_sense_in == 8'h00)[*4];
    endsequence
    // ****
    // Properties
    // ****
    property p_single;
        s_steady ##0 (!par || !listed) |-> drv == $past(cmd) && stage_grouped_out == 8'h00;
    endproperty
    a_single: assert property (p_single) else $error("single stage steering wrong");
    property p_quad;
        s_mode(ls && key == KEY_QUAD_LOWSIDE) |->
            drv == (($past(cmd) & 8'h35) | ({8{$past(cmd[3])}} & 8'hCA)) && stage_grouped_out == 8'hCA;
    endproperty
    a_quad: assert property (p_quad) else $error("quad group steering wrong");
    property p_pair;
        s_mode(ls && key == KEY_LOWSIDE_PAIR) |-> drv == (($past(cmd) & 8'hF5) | ({8{$past(cmd[3])}} & 8'h0A));
    endproperty
    a_pair: assert property (p_pair) else $error("pair steering wrong");
    property p_two;
        s_mode(ls && key == KEY_TWO_PAIRS) |->
            drv == (($past(cmd) & 8'h35) | ({8{$past(cmd[3])}} & 8'h0A) | ({8{$past(cmd[6])}} & 8'hC0));
    endproperty
    a_two: assert property (p_two) else $error("two pair steering wrong");
    property p_triple;
        s_mode(ls && key == KEY_TRIPLE) |-> drv == (($past(cmd) & 8'h37) | ({8{$past(cmd[3])}} & 8'hC8));
    endproperty
    a_triple: assert property (p_triple) else $error("triple steering wrong");
    property p_hs_a;
        s_mode(cfg == HS_PAIRS_A) |->
            drv == (($past(cmd) & 8'h3A) | ({8{$past(cmd[2])}} & 8'h05) | ({8{$past(cmd[6])}} & 8'hC0));
    endproperty
    a_hs_a: assert property (p_hs_a) else $error("first high side steering wrong");
    property p_hs_b;
        s_mode(cfg == HS_PAIRS_B) |->
            drv == (($past(cmd) & 8'hC5) | ({8{$past(cmd[3])}} & 8'h0A) | ({8{$past(cmd[4])}} & 8'h30));
    endproperty
    a_hs_b: assert property (p_hs_b) else $error("second high side steering wrong");
    property p_clear;
        live == 3'h4 ##0 s_quiet ##0 diag_rd_in |-> ##2 diag_slot_out == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("diagnosis read did not clear");
endmodule : cps_grouping_monitor

bind cps_grouping cps_grouping_monitor i_cps_grouping_monitor (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .diag_rd_in(diag_rd_in),
    .per_stage_command_in(per_stage_command_in), .oc_sense_in(oc_sense_in),
    .off_sense_in(off_sense_in), .stage_drive_out(stage_drive_out),
    .stage_grouped_out(stage_grouped_out), .diag_slot_out(diag_slot_out),
    .cps_grouping_config_out(cps_grouping_config_out),
    .general_config_seven_out(general_config_seven_out)
);

/* File: verif/tb_cps_grouping.sv */
// Self-checking bench for the stage grouping block
`timescale 1ns/1ps
module tb_cps_grouping;
    import cps_pkg::*;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic wr = 1'b0;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] cmd = 8'h00;
    logic [7:0] oc = 8'h00;
    logic [15:0] off = 16'h0000;
    logic [7:0] drv, grp, cfg_rb, seven_rb;
    logic [15:0] diag;
    integer seed = 96;
    integer num_errors = 0;
    integer checked = 0;
    integer cycles = 0;
    logic [7:0] modes [9] = '{8'h08, 8'h02, 8'h04, 8'h8C, 8'hFC, 8'h36, 8'h3A, 8'h88, 8'h0C};
    always #20 mclk_in = ~mclk_in;
    cps_grouping i_cps_grouping (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_wr_in(wr), .reg_sel_in(sel),
        .reg_wdata_in(wdata), .diag_rd_in(rd), .per_stage_command_in(cmd), .oc_sense_in(oc),
        .off_sense_in(off), .stage_drive_out(drv), .stage_grouped_out(grp), .diag_slot_out(diag),
        .cps_grouping_config_out(cfg_rb), .general_config_seven_out(seven_rb)
    );
    // ****
    // Expected behaviour: leader map, one 3-bit leader per stage
    // ****
    function automatic logic [23:0] lead_map(input logic [7:0] c, input logic p);
        if (!p || c == 8'h00) return 24'hFAC688;
        if (c == HS_PAIRS_A) return 24'hDAC68A;
        if (c == HS_PAIRS_B) return 24'hFA4698;
        case ({c[7], c[3:0]})
            KEY_QUAD_LOWSIDE: return 24'h6EC698;
            KEY_LOWSIDE_PAIR: return 24'hFAC698;
            KEY_TWO_PAIRS: return 24'hDAC698;
            KEY_TRIPLE: return 24'h6EC688;
            default: return 24'hFAC688;
        endcase
    endfunction : lead_map
    function automatic logic [31:0] model(input logic [23:0] m, input logic [7:0] c, input logic [15:0] f);
        logic [7:0] d;
        logic [7:0] g;
        logic [15:0] s;
        logic [2:0] t;
        g = 8'h00;
        s = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            d[i] = c[m[3*i +: 3]];
            for (int j = 0; j < 8; j++) if (j != i && m[3*j +: 3] == m[3*i +: 3]) g[i] = 1'b1;
        end
        for (int i = 0; i < 8; i++) begin
            t = (m[3*i +: 3] == 3'h3 && g[i] && m != 24'h6EC688) ? 3'h1 : m[3*i +: 3];
            if (f[2*i +: 2] > s[2*t +: 2]) s[2*t +: 2] = f[2*i +: 2];
        end
        return {d, g, s};
    endfunction : model
    // High and low switch of one path never on together
    function automatic logic [7:0] keep_apart(input logic [23:0] m, input logic [7:0] c);
        logic [31:0] r;
        logic [7:0] k;
        k = c;
        r = model(m, c, 16'h0000);
        if (r[24] && r[25]) k[m[5:3]] = 1'b0;
        if (r[26] && r[27]) k[m[11:9]] = 1'b0;
        if (r[28] && r[30]) k[m[20:18]] = 1'b0;
        if (r[29] && r[31]) k[m[23:21]] = 1'b0;
        return k;
    endfunction : keep_apart
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wr_reg(input logic s, input logic [7:0] v);
        @(negedge mclk_in);
        wr = 1'b1;
        sel = s;
        wdata = v;
        @(negedge mclk_in);
        wr = 1'b0;
        repeat (3) @(negedge mclk_in);
    endtask : wr_reg
    task automatic clear_diag();
        repeat (4) @(negedge mclk_in);
        rd = 1'b1;
        @(negedge mclk_in);
        rd = 1'b0;
        repeat (3) @(negedge mclk_in);
        check(diag, 16'h0000);
    endtask : clear_diag
    task automatic run_mode(input logic [7:0] c, input logic p);
        logic [23:0] m;
        logic [31:0] e;
        m = lead_map(c, p);
        wr_reg(REG_SEL_GENERAL_SEVEN, p ? 8'h00 : GENERAL_SEVEN_RESET);
        wr_reg(REG_SEL_GROUPING, c);
        check({cfg_rb, seven_rb}, {c, p ? 8'h00 : GENERAL_SEVEN_RESET});
        repeat (12) begin
            cmd = keep_apart(m, 8'($random(seed)));
            @(negedge mclk_in);
            e = model(m, cmd, 16'h0000);
            check({drv, grp}, e[31:16]);
        end
        cmd = 8'h00;
        off = 16'($random(seed));
        repeat (6) @(negedge mclk_in);
        e = model(m, 8'h00, off);
        check(diag, e[15:0]);
        for (int i = 0; i < 8; i++) if (off[2*i +: 2] != 2'h0) off[2*i +: 2] = ~off[2*i +: 2];
        repeat (6) @(negedge mclk_in);
        check(diag, e[15:0]);
        off = 16'h0000;
        clear_diag();
    endtask : run_mode
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(negedge mclk_in);
        arst_n_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        check({cfg_rb, seven_rb, drv, grp}, {GROUPING_RESET, GENERAL_SEVEN_RESET, 16'h0000});
        foreach (modes[n]) begin
            run_mode(modes[n], 1'b1);
            run_mode(modes[n], 1'b0);
        end
        repeat (4) run_mode(8'($random(seed)), 1'b1);
        // Overcurrent filter: stage 21 single, stage 22 grouped under quad
        run_mode(8'h08, 1'b1);
        // Off fault on stage 21 first, later overwritten by its on fault
        off = 16'h0001;
        repeat (6) @(negedge mclk_in);
        check(diag, 16'h0001);
        off = 16'h0000;
        cmd = 8'h09;
        oc = 8'h03;
        repeat (90) @(negedge mclk_in);
        check(diag, 16'h0001);
        repeat (30) @(negedge mclk_in);
        check(diag, 16'h0003);
        repeat (70) @(negedge mclk_in);
        check(diag, 16'h0003);
        repeat (30) @(negedge mclk_in);
        check(diag, 16'h000F);
        cmd = 8'h00;
        oc = 8'h00;
        clear_diag();
        wrap_up();
    end
endmodule : tb_cps_grouping
